// file: tb/iwsc_checker.sv
// Purpose: Port-level properties of the idle wake controller
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to iwsc_top, sees only its ports
`timescale 1ns/100ps
module iwsc_checker #(
  parameter [16:0] PSU_CYCLES = 17'h186A0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic core_wfi,
  input wire logic hard_reset_pin_n,
  input wire logic battery_fault_in,
  input wire logic vdd_fault_in,
  input wire logic cpu_clk_en_r,
  input wire logic wfi_done_r,
  input wire logic irq_take_r,
  input wire logic core_rst_r,
  input wire logic sleep_r,
  input wire logic core_clock_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////
  a_done_pulse: assert property (
    wfi_done_r |=> !wfi_done_r) else $error("Completion pulse too long");
  a_take_done: assert property (
    irq_take_r |-> wfi_done_r) else $error("Vector taken without resume");
  a_take_pulse: assert property (
    irq_take_r |=> !irq_take_r) else $error("Vector pulse too long");
  // Idle entry drops the clocks and clock switching together
  a_idle_entry: assert property (
    core_wfi && cpu_clk_en_r && $past(cpu_clk_en_r) && !wfi_done_r &&
    !core_rst_r && !sleep_r && hard_reset_pin_n
    |=> !cpu_clk_en_r && !core_clock_out)
    else $error("Idle entry did not stop clocks");
  a_wake_done: assert property (
    $rose(cpu_clk_en_r) && !core_rst_r && !$past(core_rst_r) &&
    !$past(core_rst_r, 2) && !sleep_r && !$past(sleep_r)
    |=> wfi_done_r) else $error("Wake without completion");
  a_done_clocks: assert property (
    wfi_done_r |-> cpu_clk_en_r && $past(cpu_clk_en_r) &&
    !$past(cpu_clk_en_r, 2)) else $error("Completion out of step");
  a_pin_reset: assert property (
    !hard_reset_pin_n |=> core_rst_r) else $error("Pin did not reset");
  a_pin_hold: assert property (
    $rose(hard_reset_pin_n) |-> core_rst_r [*4] ##[1:3] !core_rst_r)
    else $error("Reset stretch wrong");
  // A fault reaches the mode logic only through two flops
  a_fault_sync: assert property (
    $rose(sleep_r) |-> ($past(vdd_fault_in, 2) && $past(vdd_fault_in, 3))
    || ($past(battery_fault_in, 2) && $past(battery_fault_in, 3)))
    else $error("Sleep without synchronised fault");
endmodule // iwsc_checker

// file: tb/iwsc_core_model.sv
// Purpose: Behavioural processor core facing the idle controller
// Assumes: go_idle is a one-cycle request from the bench
// Notes:   Counts how execution resumed after each WFI completion, not exits through reset
`timescale 1ns/100ps
module iwsc_core_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        go_idle,
  input  wire logic        wfi_done_r,
  input  wire logic        irq_take_r,
  input  wire logic        core_rst_r,
  output logic             core_wfi,
  output logic [31:0]      resume_cnt,
  output logic [31:0]      vector_cnt
);
  logic pend_r;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_wfi <= 1'b0;
      pend_r <= 1'b0;
      resume_cnt <= 32'h0;
      vector_cnt <= 32'h0;
    end else begin
      // Core stalls on its wait until completion or reset
      core_wfi <= go_idle && !pend_r;
      if (go_idle && !pend_r) pend_r <= 1'b1;
      if (core_rst_r) pend_r <= 1'b0;
      if (wfi_done_r) begin
        pend_r <= 1'b0;
        resume_cnt <= resume_cnt + 32'h1;
        if (irq_take_r) vector_cnt <= vector_cnt + 32'h1;
      end
    end
  end
endmodule // iwsc_core_model

// file: tb/iwsc_tb_top.sv
// Purpose: Self-checking bench for the idle wake controller
// Assumes: Short supply timer cycle so blanking ends quickly
// Notes:   Core side played by iwsc_core_model
`timescale 1ns/100ps
`include "iwsc_defines.vh"
module iwsc_tb_top;
  localparam [16:0] PSU = 17'h14;
  logic        ref_clk = 0, sys_rst = 1, go_idle = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, irq_src = 0;
  logic [31:0] wdata = 0, rdata, resumes, vectors, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, resp;
  logic        pin_n = 1, batt = 0, vdd = 0, core_wfi;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        clk_en, done, take, crst, slp, cswitch, irq_out;
  int          miscompares = 0, samples_checked = 0, cyc = 0, n, k;
  always #50 ref_clk = ~ref_clk;
  iwsc_top #(.PSU_CYCLES(PSU)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq_src(irq_src), .core_wfi(core_wfi), .hard_reset_pin_n(pin_n),
    .battery_fault_in(batt), .vdd_fault_in(vdd), .cpu_clk_en_r(clk_en),
    .wfi_done_r(done), .irq_take_r(take), .core_rst_r(crst),
    .sleep_r(slp), .core_clock_out(cswitch), .irq_out_r(irq_out));
  iwsc_core_model CORE (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .go_idle(go_idle),
    .wfi_done_r(done), .irq_take_r(take), .core_rst_r(crst),
    .core_wfi(core_wfi), .resume_cnt(resumes), .vector_cnt(vectors));
  //////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return done;
      1: return crst;
      2: return slp;
      default: return irq_out;
    endcase
  endfunction
  // Bounded wait for an output level, then judge it
  task till(input int s, input logic v, input int lim);
    for (n = 0; n < lim && pick(s) !== v; n++) @(posedge ref_clk);
    chk(pick(s), v);
  endtask
  task idle;
    go_idle <= 1'b1;
    @(posedge ref_clk);
    go_idle <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(clk_en, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(clk_en, 1'b1);
    chk(cswitch, 1'b0);
    rd(`IWSC_OFF_CTRL);
    chk(d, 32'h0);
    rd(`IWSC_OFF_MATCH);
    chk(d, `IWSC_RST_MATCH);
    // Byte strobes must reach only the addressed byte of the match word
    wstrb <= 4'h1;
    wr(`IWSC_OFF_MATCH, 32'h00000012);
    wstrb <= 4'hF;
    rd(`IWSC_OFF_MATCH);
    chk(d, 32'hFFFFFF12);
    rd(8'h20);
    chk(resp, `IWSC_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h24, 32'h1);
    chk(resp, `IWSC_RESP_SLVERR);
  endtask
  task t_wake(input logic unmasked);
    wr(`IWSC_OFF_IRQ_EN, 32'h1);
    wr(`IWSC_OFF_IRQ_MASK, {31'h0, unmasked});
    wr(`IWSC_OFF_EVT_MASK, 32'h1);
    wr(`IWSC_OFF_CTRL, 32'h2);
    idle;
    chk(cswitch, 1'b0);
    rd(`IWSC_OFF_MODE);
    chk(d[5:0], 6'h02);
    irq_src <= 8'h02;
    repeat (4) @(posedge ref_clk);
    chk(clk_en, 1'b0);
    irq_src <= 8'h03;
    till(0, 1'b1, 8);
    chk(take, unmasked);
    irq_src <= 8'h00;
    till(3, 1'b1, 4);
    rd(`IWSC_OFF_EVT);
    chk(d[3:0], 4'h1);
    rd(`IWSC_OFF_EVT);
    chk(d[3:0], 4'h0);
    chk(irq_out, 1'b0);
    wr(`IWSC_OFF_CTRL, 32'h2);
    @(posedge ref_clk);
    chk(cswitch, 1'b1);
  endtask
  task t_vdd;
    idle;
    irq_src <= 8'h01;
    till(0, 1'b1, 8);
    irq_src <= 8'h00;
    vdd <= 1'b1;
    // Sleep must wait while the supply timer still blanks the fault
    for (k = 0; k < 12; k++) begin
      rd(`IWSC_OFF_MODE);
      if (!d[6]) break;
      chk(slp, 1'b0);
    end
    till(2, 1'b1, 10);
    rd(`IWSC_OFF_EVT);
    chk(d[1], 1'b1);
    vdd <= 1'b0;
    irq_src <= 8'h01;
    till(2, 1'b0, 10);
    irq_src <= 8'h00;
    till(1, 1'b0, 16);
  endtask
  task t_pin;
    idle;
    pin_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(crst, 1'b1);
    pin_n <= 1'b1;
    till(1, 1'b0, 12);
    rd(`IWSC_OFF_EVT);
    chk(d[3], 1'b1);
  endtask
  task t_wdog;
    rd(`IWSC_OFF_COUNT);
    wr(`IWSC_OFF_MATCH, d + 32'h3C);
    wr(`IWSC_OFF_CTRL, 32'h4);
    idle;
    till(1, 1'b1, 80);
    till(1, 1'b0, 16);
    wr(`IWSC_OFF_CTRL, 32'h0);
    rd(`IWSC_OFF_EVT);
    chk(d[2], 1'b1);
  endtask
  task t_batt;
    batt <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(slp, 1'b0);
    idle;
    till(2, 1'b1, 8);
    batt <= 1'b0;
    irq_src <= 8'h01;
    till(2, 1'b0, 10);
    irq_src <= 8'h00;
    till(1, 1'b0, 16);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_wake(1'b0);
    t_wake(1'b1);
    chk(resumes, 32'h2);
    chk(vectors, 32'h1);
    t_vdd;
    t_pin;
    t_wdog;
    t_batt;
    stop_test;
  end
endmodule // iwsc_tb_top

bind iwsc_top iwsc_checker #(.PSU_CYCLES(PSU_CYCLES)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .core_wfi(core_wfi),
  .hard_reset_pin_n(hard_reset_pin_n), .battery_fault_in(battery_fault_in),
  .vdd_fault_in(vdd_fault_in), .cpu_clk_en_r(cpu_clk_en_r),
  .wfi_done_r(wfi_done_r), .irq_take_r(irq_take_r),
  .core_rst_r(core_rst_r), .sleep_r(sleep_r),
  .core_clock_out(core_clock_out));

// file: verilog/iwsc_defines.vh
// Purpose: Constants for the idle wake and sleep controller
// Assumes: 10 MHz reference clock
// Notes:   Offsets are AXI4-Lite byte addresses
`ifndef IWSC_DEFINES_VH
`define IWSC_DEFINES_VH

// Register byte offsets
`define IWSC_OFF_CTRL     8'h00
`define IWSC_OFF_MODE     8'h04
`define IWSC_OFF_IRQ_EN   8'h08
`define IWSC_OFF_IRQ_MASK 8'h0C
`define IWSC_OFF_MATCH    8'h10
`define IWSC_OFF_COUNT    8'h14
`define IWSC_OFF_EVT      8'h18
`define IWSC_OFF_EVT_MASK 8'h1C

// Control fields
`define IWSC_CTRL_CLKSW   1
`define IWSC_CTRL_WDOG    2

// Event bits
`define IWSC_EVT_WAKE     0
`define IWSC_EVT_SLEEP    1
`define IWSC_EVT_WDOG     2
`define IWSC_EVT_PIN      3
`define IWSC_EVT_W        4

// Reset values
`define IWSC_RST_MATCH    32'hFFFFFFFF
`define IWSC_RST_WORD     32'h00000000

// Widths
`define IWSC_IRQ_W        8
`define IWSC_PSU_CW       17

// Timing
`define IWSC_CLK_KHZ      10000
`define IWSC_PSU_MS       10
// Sized to the timer width: 10 ms of 10 MHz clock, 100000 cycles
`define IWSC_PSU_CYCLES   17'h186A0
`define IWSC_RST_HOLD     3'h4

// Bus responses
`define IWSC_RESP_OKAY    2'h0
`define IWSC_RESP_SLVERR  2'h2

`endif

// file: verilog/iwsc_psu_timer.v
// Purpose: Free-running supply timer with fault blanking window
// Assumes: wake is a one-cycle pulse
// Notes:   Blanking ends at the end of the current timer cycle
`timescale 1ns/100ps
`include "iwsc_defines.vh"
module iwsc_psu_timer (
  ref_clk,
  sys_rst,
  wake,
  blank_r
);
  parameter [`IWSC_PSU_CW-1:0] CYCLES = `IWSC_PSU_CYCLES;

  input  wire ref_clk;
  input  wire sys_rst;
  input  wire wake;
  output reg  blank_r;

  reg [`IWSC_PSU_CW-1:0] cnt_r;
  wire                   wrap;

  assign wrap = (cnt_r == CYCLES - 1'b1);

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r   <= {`IWSC_PSU_CW{1'b0}};
      blank_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? {`IWSC_PSU_CW{1'b0}} : cnt_r + 1'b1;
      // A wake on the wrap cycle must still blank a full cycle
      if (wake)
        blank_r <= 1'b1;
      else if (wrap)
        blank_r <= 1'b0;
    end
  end
endmodule // iwsc_psu_timer

// file: verilog/iwsc_sync2.v
// Purpose: Two-stage synchroniser, one per bit
// Assumes: Inputs are levels
// Notes:   Stage one feeds stage two only
`timescale 1ns/100ps
module iwsc_sync2 (
  ref_clk,
  sys_rst,
  din,
  dout_r
);
  input  wire       ref_clk;
  input  wire       sys_rst;
  input  wire [1:0] din;
  output wire [1:0] dout_r;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= din[g];
          sync_r <= meta_r;
        end
      end
      assign dout_r[g] = sync_r;
    end
  endgenerate
endmodule // iwsc_sync2

// file: verilog/iwsc_top.v
// Purpose: Idle exit, watchdog reset and supply-fault sleep control
// Assumes: All pins synchronous to ref_clk except the two fault inputs
// Notes:   AXI4-Lite slave, one write and one read in flight
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "iwsc_defines.vh"

// Operation
// - Enabled interrupt ends idle, back to run
// - Mask ignored when deciding idle wake-up
// - Wake restarts clocks, completes WFI, resumes
// - Masked waker: continue after WFI, no vector
// - Unmasked waker: take the interrupt vector
// - Reset pin low in idle ends idle
// - Watchdog match on channel three asserts reset
// - Enabled watchdog keeps counting during idle
// - Battery or supply fault in idle: sleep
// - Supply fault input causes sleep entry
// - Supply fault ignored after wake until the current timer cycle ends
// - Clock switching disabled at reset
module iwsc_top (
  ref_clk,
  sys_rst,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_awaddr,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_bresp,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_araddr,
  s_axi_rvalid,
  s_axi_rready,
  s_axi_rdata,
  s_axi_rresp,
  irq_src,
  core_wfi,
  hard_reset_pin_n,
  battery_fault_in,
  vdd_fault_in,
  cpu_clk_en_r,
  wfi_done_r,
  irq_take_r,
  core_rst_r,
  sleep_r,
  core_clock_out,
  irq_out_r
);
  parameter [`IWSC_PSU_CW-1:0] PSU_CYCLES = `IWSC_PSU_CYCLES;

  input  wire                   ref_clk;
  input  wire                   sys_rst;
  input  wire                   s_axi_awvalid;
  output reg                    s_axi_awready;
  input  wire [7:0]             s_axi_awaddr;
  input  wire                   s_axi_wvalid;
  output reg                    s_axi_wready;
  input  wire [31:0]            s_axi_wdata;
  input  wire [3:0]             s_axi_wstrb;
  output reg                    s_axi_bvalid;
  input  wire                   s_axi_bready;
  output reg  [1:0]             s_axi_bresp;
  input  wire                   s_axi_arvalid;
  output reg                    s_axi_arready;
  input  wire [7:0]             s_axi_araddr;
  output reg                    s_axi_rvalid;
  input  wire                   s_axi_rready;
  output reg  [31:0]            s_axi_rdata;
  output reg  [1:0]             s_axi_rresp;
  input  wire [`IWSC_IRQ_W-1:0] irq_src;
  input  wire                   core_wfi;
  input  wire                   hard_reset_pin_n;
  input  wire                   battery_fault_in;
  input  wire                   vdd_fault_in;
  output reg                    cpu_clk_en_r;
  output reg                    wfi_done_r;
  output reg                    irq_take_r;
  output reg                    core_rst_r;
  output reg                    sleep_r;
  output reg                    core_clock_out;
  output reg                    irq_out_r;

  localparam [5:0] ST_RUN    = 6'h01;
  localparam [5:0] ST_IDLE   = 6'h02;
  localparam [5:0] ST_WAKE   = 6'h04;
  localparam [5:0] ST_RESUME = 6'h08;
  localparam [5:0] ST_SLEEP  = 6'h10;
  localparam [5:0] ST_RST    = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Fault synchronisers and supply timer

  wire [1:0] fault_s;
  wire       batt_s;
  wire       vdd_s;
  wire       blank;
  reg        wake_evt_r;

  iwsc_sync2 u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     ({vdd_fault_in, battery_fault_in}),
    .dout_r  (fault_s)
  );

  assign batt_s = fault_s[0];
  assign vdd_s  = fault_s[1];

  iwsc_psu_timer #(.CYCLES(PSU_CYCLES)) u_psu (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wake    (wake_evt_r),
    .blank_r (blank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and watchdog

  reg [5:0]             state_r;
  reg [5:0]             state_nxt;
  reg [2:0]             rst_cnt_r;
  reg                   wdog_en_r;
  reg [`IWSC_IRQ_W-1:0] irq_en_r;
  reg [`IWSC_IRQ_W-1:0] interrupt_mask_reg;
  reg [31:0]            timer_match_reg;
  reg [31:0]            count_r;
  reg [`IWSC_EVT_W-1:0] evt_r;
  reg [`IWSC_EVT_W-1:0] evt_mask_r;
  reg                   waker_unmasked_r;
  reg                   aw_got_r;
  reg                   w_got_r;
  reg [7:0]             aw_addr_r;
  reg [31:0]            w_data_r;
  reg [3:0]             w_strb_r;

  wire                   wr_fire;
  wire                   rd_fire;
  wire [`IWSC_IRQ_W-1:0] pend;
  wire                   wake_req;
  wire                   vdd_live;
  wire                   wdog_hit;
  wire                   pin_rst;
  wire [`IWSC_EVT_W-1:0] evt_set;
  wire [`IWSC_EVT_W-1:0] evt_nxt;

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          wmerge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  assign wr_fire  = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign rd_fire  = s_axi_arvalid & s_axi_arready;
  // Mask plays no part in waking, only in vector selection
  assign pend     = irq_src & irq_en_r;
  assign wake_req = |pend;
  assign vdd_live = vdd_s & ~blank;
  // Counter never stops in idle, so the watchdog stays armed
  assign wdog_hit = wdog_en_r & (count_r == timer_match_reg);
  assign pin_rst  = ~hard_reset_pin_n;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      count_r <= `IWSC_RST_WORD;
    else
      count_r <= count_r + 32'h00000001;
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_clock_out     <= 1'b0;
      wdog_en_r          <= 1'b0;
      irq_en_r           <= {`IWSC_IRQ_W{1'b0}};
      interrupt_mask_reg <= {`IWSC_IRQ_W{1'b0}};
      timer_match_reg    <= `IWSC_RST_MATCH;
      evt_mask_r         <= {`IWSC_EVT_W{1'b0}};
    end else begin
      if (wr_fire) begin
        case (aw_addr_r)
          `IWSC_OFF_CTRL: if (w_strb_r[0]) begin
            core_clock_out <= w_data_r[`IWSC_CTRL_CLKSW];
            wdog_en_r      <= w_data_r[`IWSC_CTRL_WDOG];
          end
          `IWSC_OFF_IRQ_EN: if (w_strb_r[0])
            irq_en_r <= w_data_r[`IWSC_IRQ_W-1:0];
          `IWSC_OFF_IRQ_MASK: if (w_strb_r[0])
            interrupt_mask_reg <= w_data_r[`IWSC_IRQ_W-1:0];
          `IWSC_OFF_MATCH:
            timer_match_reg <= wmerge(timer_match_reg, w_data_r, w_strb_r);
          `IWSC_OFF_EVT_MASK: if (w_strb_r[0])
            evt_mask_r <= w_data_r[`IWSC_EVT_W-1:0];
          default: ;
        endcase
      end
      // Idle entry and every core reset drop back to the memory clock
      if ((state_r == ST_RUN && core_wfi) || state_nxt == ST_RST)
        core_clock_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  always @* begin
    state_nxt = state_r;
    if (pin_rst || wdog_hit) begin
      state_nxt = ST_RST;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (vdd_live)
            state_nxt = ST_SLEEP;
          else if (core_wfi)
            state_nxt = ST_IDLE;
        end
        ST_IDLE: begin
          if (batt_s || vdd_live)
            state_nxt = ST_SLEEP;
          else if (wake_req)
            state_nxt = ST_WAKE;
        end
        ST_WAKE:   state_nxt = ST_RESUME;
        ST_RESUME: state_nxt = ST_RUN;
        ST_SLEEP: begin
          if (wake_req)
            state_nxt = ST_RST;
        end
        ST_RST: begin
          if (rst_cnt_r == 3'h0)
            state_nxt = ST_RUN;
        end
        default:   state_nxt = ST_RST;
      endcase
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r          <= ST_RUN;
      rst_cnt_r        <= 3'h0;
      cpu_clk_en_r     <= 1'b1;
      wfi_done_r       <= 1'b0;
      irq_take_r       <= 1'b0;
      core_rst_r       <= 1'b0;
      sleep_r          <= 1'b0;
      waker_unmasked_r <= 1'b0;
      wake_evt_r       <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      wfi_done_r <= 1'b0;
      irq_take_r <= 1'b0;
      wake_evt_r <= 1'b0;
      if (state_nxt == ST_RST && state_r != ST_RST)
        rst_cnt_r <= `IWSC_RST_HOLD;
      else if (state_r == ST_RST && (pin_rst || wdog_hit))
        rst_cnt_r <= `IWSC_RST_HOLD;
      else if (rst_cnt_r != 3'h0)
        rst_cnt_r <= rst_cnt_r - 3'h1;
      core_rst_r   <= (state_nxt == ST_RST);
      sleep_r      <= (state_nxt == ST_SLEEP);
      cpu_clk_en_r <= (state_nxt == ST_RUN) || (state_nxt == ST_WAKE)
                      || (state_nxt == ST_RESUME);
      if (state_r == ST_IDLE && state_nxt == ST_WAKE) begin
        waker_unmasked_r <= |(pend & interrupt_mask_reg);
        wake_evt_r       <= 1'b1;
      end
      if (state_r == ST_SLEEP && state_nxt == ST_RST)
        wake_evt_r <= 1'b1;
      if (state_r == ST_WAKE) begin
        wfi_done_r <= 1'b1;
        irq_take_r <= waker_unmasked_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  assign evt_set = {state_nxt == ST_RST && state_r != ST_RST && pin_rst,
                    state_nxt == ST_RST && state_r != ST_RST && wdog_hit,
                    state_nxt == ST_SLEEP && state_r != ST_SLEEP,
                    state_r == ST_WAKE};
  // A set in the read cycle survives the read clear
  assign evt_nxt = evt_set |
                   ((rd_fire && s_axi_araddr == `IWSC_OFF_EVT) ?
                    {`IWSC_EVT_W{1'b0}} : evt_r);

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_r     <= {`IWSC_EVT_W{1'b0}};
      irq_out_r <= 1'b0;
    end else begin
      evt_r     <= evt_nxt;
      irq_out_r <= |(evt_nxt & evt_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IWSC_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= `IWSC_RST_WORD;
      w_strb_r      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          `IWSC_OFF_CTRL, `IWSC_OFF_IRQ_EN, `IWSC_OFF_IRQ_MASK,
          `IWSC_OFF_MATCH, `IWSC_OFF_EVT_MASK:
            s_axi_bresp <= `IWSC_RESP_OKAY;
          default:
            s_axi_bresp <= `IWSC_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `IWSC_RST_WORD;
      s_axi_rresp   <= `IWSC_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `IWSC_RESP_OKAY;
        s_axi_rdata   <= `IWSC_RST_WORD;
        case (s_axi_araddr)
          `IWSC_OFF_CTRL:
            s_axi_rdata[2:0] <= {wdog_en_r, core_clock_out, 1'b0};
          `IWSC_OFF_MODE:
            s_axi_rdata[7:0] <= {waker_unmasked_r, blank, state_r};
          `IWSC_OFF_IRQ_EN:
            s_axi_rdata[`IWSC_IRQ_W-1:0] <= irq_en_r;
          `IWSC_OFF_IRQ_MASK:
            s_axi_rdata[`IWSC_IRQ_W-1:0] <= interrupt_mask_reg;
          `IWSC_OFF_MATCH:    s_axi_rdata <= timer_match_reg;
          `IWSC_OFF_COUNT:    s_axi_rdata <= count_r;
          `IWSC_OFF_EVT:
            s_axi_rdata[`IWSC_EVT_W-1:0] <= evt_r;
          `IWSC_OFF_EVT_MASK:
            s_axi_rdata[`IWSC_EVT_W-1:0] <= evt_mask_r;
          default:
            s_axi_rresp <= `IWSC_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // iwsc_top
